// ---- hw/fpu_dec_pkg.sv ----
// shared encodings, register map and carrier types of the fp decoder
// assumes 32-bit instruction words and a 32-bit axi4-lite register bus
package fpu_dec_pkg;
  // ----------------------------------------------------------------
  // instruction encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_FP_COPROC_OPCODE = 6'h11;
  localparam logic [4:0] SUB_BC = 5'h08;
  localparam logic [4:0] FMT_S = 5'h10;
  localparam logic [4:0] FMT_D = 5'h11;
  localparam logic [4:0] FMT_W = 5'h14;
  localparam logic [4:0] FMT_L = 5'h15;
  localparam logic [4:0] FT_ZERO = 5'h00;
  localparam logic [2:0] SEL_ZERO = 3'h0;
  localparam logic [5:0] FN_ADD = 6'h00;
  localparam logic [5:0] FN_SUB = 6'h01;
  localparam logic [5:0] FN_DIV = 6'h03;
  localparam logic [5:0] FN_SQRT = 6'h04;
  localparam logic [5:0] FN_ABS = 6'h05;
  localparam logic [5:0] FN_MOV = 6'h06;
  localparam logic [5:0] FN_NEG = 6'h07;
  localparam logic [5:0] FN_ROUND_L = 6'h08;
  localparam logic [5:0] FN_TRUNC_L = 6'h09;
  localparam logic [5:0] FN_CEIL_L = 6'h0A;
  localparam logic [5:0] FN_FLOOR_L = 6'h0B;
  localparam logic [5:0] FN_ROUND_W = 6'h0C;
  localparam logic [5:0] FN_TRUNC_W = 6'h0D;
  localparam logic [5:0] FN_CEIL_W = 6'h0E;
  localparam logic [5:0] FN_FLOOR_W = 6'h0F;
  localparam logic [5:0] FN_MOVCF = 6'h11;
  localparam logic [5:0] FN_MOVZ = 6'h12;
  localparam logic [5:0] FN_MOVN = 6'h13;
  localparam logic [5:0] FN_RECIP = 6'h15;
  localparam logic [5:0] FN_RSQRT = 6'h16;
  localparam logic [5:0] FN_CONVERT_TO_SINGLE_OP = 6'h20;
  localparam logic [5:0] FN_CONVERT_TO_DOUBLE_OP = 6'h21;
  localparam logic [5:0] FN_CVT_W = 6'h24;
  localparam logic [5:0] FN_CVT_L = 6'h25;
  localparam logic [5:0] FN_CMP_MASK = 6'h30;
  localparam logic [31:0] INSTR_BYTES = 32'h4;
  localparam int COND_W = 8;
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LVL_I = 2'h0, LVL_II = 2'h1, LVL_III = 2'h2,
                            LVL_IV = 2'h3} isa_level_t;
  typedef enum logic [2:0] {EXC_NONE = 3'h0, EXC_COP_UNUSABLE = 3'h1,
                            EXC_RESERVED = 3'h2, EXC_UNIMPL = 3'h3,
                            EXC_INVALID = 3'h4, EXC_OVERFLOW = 3'h5,
                            EXC_UNDERFLOW = 3'h6, EXC_INEXACT = 3'h7} exc_t;
  localparam int FLG_INX = 0;
  localparam int FLG_UNF = 1;
  localparam int FLG_OVF = 2;
  localparam int FLG_INV = 3;
  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] opc; logic [4:0] fmt; logic [4:0] ft;
    logic [4:0] fs; logic [4:0] fd; logic [5:0] funct;
  } arith_fields_t;
  typedef struct packed {
    logic [5:0] opc; logic [4:0] sub; logic [2:0] sel;
    logic nd; logic tf; logic [15:0] offset;
  } branch_fields_t;
  typedef struct packed {
    logic [3:0] trap_en; logic [1:0] round_mode; logic usable; isa_level_t level;
  } ctrl_t;
  localparam int CTRL_W = $bits(ctrl_t);
  localparam ctrl_t CTRL_RST = '{trap_en: 4'h0, round_mode: 2'h0, usable: 1'b1,
                                 level: LVL_IV};
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_COND = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [COND_W-1:0] COND_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fpu_dec_pkg

// ---- hw/fp_format_check.sv ----
// operand format legality of each fp operation
// assumes the caller has already picked out a non-branch coprocessor word
module fp_format_check (
  // decoded fields
  input wire logic [4:0] fmt,
  input wire logic [5:0] funct,
  // verdict
  output logic known,
  output logic legal
);
  logic src_fp;
  logic src_fix;
  assign src_fp = (fmt == fpu_dec_pkg::FMT_S) | (fmt == fpu_dec_pkg::FMT_D);
  assign src_fix = (fmt == fpu_dec_pkg::FMT_W) | (fmt == fpu_dec_pkg::FMT_L);

  always_comb begin
    known = 1'b1;
    legal = 1'b0;
    if ((funct & fpu_dec_pkg::FN_CMP_MASK) == fpu_dec_pkg::FN_CMP_MASK) begin
      legal = src_fp;
    end else begin
      case (funct)
        fpu_dec_pkg::FN_ABS, fpu_dec_pkg::FN_ADD, fpu_dec_pkg::FN_SUB,
        fpu_dec_pkg::FN_DIV, fpu_dec_pkg::FN_SQRT, fpu_dec_pkg::FN_MOV,
        fpu_dec_pkg::FN_NEG, fpu_dec_pkg::FN_MOVCF, fpu_dec_pkg::FN_MOVZ,
        fpu_dec_pkg::FN_MOVN, fpu_dec_pkg::FN_RECIP, fpu_dec_pkg::FN_RSQRT: begin
          legal = src_fp;
        end
        fpu_dec_pkg::FN_ROUND_L, fpu_dec_pkg::FN_TRUNC_L, fpu_dec_pkg::FN_CEIL_L,
        fpu_dec_pkg::FN_FLOOR_L, fpu_dec_pkg::FN_ROUND_W, fpu_dec_pkg::FN_TRUNC_W,
        fpu_dec_pkg::FN_CEIL_W, fpu_dec_pkg::FN_FLOOR_W, fpu_dec_pkg::FN_CVT_W,
        fpu_dec_pkg::FN_CVT_L: begin
          legal = src_fp;
        end
        fpu_dec_pkg::FN_CONVERT_TO_DOUBLE_OP: begin
          legal = (fmt == fpu_dec_pkg::FMT_S) | src_fix;
        end
        fpu_dec_pkg::FN_CONVERT_TO_SINGLE_OP: begin
          legal = (fmt == fpu_dec_pkg::FMT_D) | src_fix;
        end
        default: begin
          known = 1'b0;
        end
      endcase
    end
  end
endmodule : fp_format_check

// ---- hw/fpu_branch_decoder.sv ----
// fp coprocessor decoder: format checks, magnitude, add hand-off, fp branch
// assumes a host pipeline on SYS_CLK and an external add datapath
//
// Overview of operation
// - arithmetic ops take single/double only, else unimplemented
// - fixed-point conversions reject fixed-point sources
// - to-double rejects double, to-single rejects single
// - magnitude op decoded, clears sign into destination
// - magnitude of NaN signals invalid operation
// - add sums sources with current rounding mode
// - add may raise seven listed exceptions
// - wrong-format operand gives undefined result
// - branch decoded with selector, nullify and sense bits
// - target is delay-slot address plus shifted offset
// - matching condition runs slot then redirects
// - likely variant nullifies slot when not taken
// - level four tests selected bit of eight
// - lower levels use condition from previous instruction
// - no interlock; back-to-back branch sees stale condition
// - branch raises only unusable, reserved, unimplemented
// - format field decodes single, double, word, long
// - exactly one delay slot before redirection
// - unsupported formats report unimplemented operation
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
module fpu_branch_decoder #(
  parameter int TRAP_CNT_W = 8
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // axi4-lite register slave
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [11:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [11:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // instruction issue
  input wire logic ISSUE_VALID,
  output logic ISSUE_READY,
  input wire logic [31:0] ISSUE_INSTR,
  input wire logic [31:0] ISSUE_PC,
  input wire logic [63:0] SRC_A,
  input wire logic [63:0] SRC_B,
  // compare results
  input wire logic CMP_VALID,
  input wire logic [2:0] CMP_SEL,
  input wire logic CMP_RESULT,
  // add datapath
  output logic ADD_REQ,
  output logic ADD_DOUBLE,
  output logic [1:0] ROUND_MODE,
  output logic [63:0] ADD_A,
  output logic [63:0] ADD_B,
  input wire logic ARITH_DONE,
  input wire logic [63:0] ARITH_RESULT,
  input wire logic [3:0] ARITH_FLAGS,
  // completion
  output logic DONE,
  output logic EXC_VALID,
  output logic [2:0] EXC_CAUSE,
  output logic DEST_WE,
  output logic [4:0] DEST_REG,
  output logic [63:0] DEST_DATA,
  output logic BR_VALID,
  output logic BR_TAKEN,
  output logic [31:0] BR_TARGET,
  output logic NULLIFY_SLOT,
  output logic COND_SIGNAL
);
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ADD = 2'h1} state_t;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  fpu_dec_pkg::arith_fields_t af;
  fpu_dec_pkg::branch_fields_t bf;
  fpu_dec_pkg::ctrl_t ctrl_q;
  fpu_dec_pkg::exc_t exc_d;
  fpu_dec_pkg::exc_t flag_exc;
  state_t state_q;
  logic [fpu_dec_pkg::COND_W-1:0] fcc_q;
  logic c0_prev_q;
  logic known;
  logic legal;
  assign af = fpu_dec_pkg::arith_fields_t'(ISSUE_INSTR);
  assign bf = fpu_dec_pkg::branch_fields_t'(ISSUE_INSTR);

  fp_format_check u_fmt (
    .fmt(af.fmt),
    .funct(af.funct),
    .known(known),
    .legal(legal)
  );

  wire logic issue_fire = ISSUE_VALID & ISSUE_READY;
  wire logic is_fp_coproc_opcode = af.opc == fpu_dec_pkg::OPC_FP_COPROC_OPCODE;
  wire logic is_bc = is_fp_coproc_opcode & (bf.sub == fpu_dec_pkg::SUB_BC);
  wire logic is_op = is_fp_coproc_opcode & ~is_bc;
  wire logic is_abs = is_op & (af.funct == fpu_dec_pkg::FN_ABS);
  wire logic is_add = is_op & (af.funct == fpu_dec_pkg::FN_ADD);
  wire logic is_dbl = af.fmt == fpu_dec_pkg::FMT_D;
  wire logic lvl4 = ctrl_q.level == fpu_dec_pkg::LVL_IV;
  wire logic lvl1 = ctrl_q.level == fpu_dec_pkg::LVL_I;
  // selector must be zero below level four; likely forms need level two
  wire logic bc_bad = is_bc & ((~lvl4 & (bf.sel != fpu_dec_pkg::SEL_ZERO))
                               | (bf.nd & lvl1));
  wire logic op_bad = is_op & (~known | (is_abs & (af.ft != fpu_dec_pkg::FT_ZERO)));
  wire logic nan_s = (&SRC_A[30:23]) & (|SRC_A[22:0]);
  wire logic nan_d = (&SRC_A[62:52]) & (|SRC_A[51:0]);
  wire logic abs_nan = is_abs & (is_dbl ? nan_d : nan_s);
  wire logic [63:0] sign_mask = is_dbl ? 64'h8000000000000000 : 64'h0000000080000000;
  // clearing only the sign keeps NaN payloads and wrong-format data as is
  wire logic [63:0] abs_val = SRC_A & ~sign_mask;

  // priority: opcode, then usability, then encoding, then format, then data
  assign exc_d = ~is_fp_coproc_opcode ? fpu_dec_pkg::EXC_RESERVED
               : ~ctrl_q.usable ? fpu_dec_pkg::EXC_COP_UNUSABLE
               : (bc_bad | op_bad) ? fpu_dec_pkg::EXC_RESERVED
               : (is_op & ~legal) ? fpu_dec_pkg::EXC_UNIMPL
               : (abs_nan & ctrl_q.trap_en[fpu_dec_pkg::FLG_INV])
                 ? fpu_dec_pkg::EXC_INVALID : fpu_dec_pkg::EXC_NONE;
  wire logic ok = exc_d == fpu_dec_pkg::EXC_NONE;

  // ----------------------------------------------------------------
  // branch evaluation
  // ----------------------------------------------------------------
  // lower levels test the condition as it stood one instruction earlier
  wire logic cond_bit = lvl4 ? fcc_q[bf.sel] : c0_prev_q;
  wire logic taken = cond_bit == bf.tf;
  wire logic [31:0] off_ext = 32'(signed'({bf.offset, 2'b00}));
  wire logic [31:0] target = ISSUE_PC + fpu_dec_pkg::INSTR_BYTES + off_ext;
  wire logic br_ok = issue_fire & is_bc & ok;

  // ----------------------------------------------------------------
  // add hand-off
  // ----------------------------------------------------------------
  wire logic start_add = issue_fire & is_add & ok;
  wire logic add_back = (state_q == ST_ADD) & ARITH_DONE;
  wire logic [3:0] trap_flags = ARITH_FLAGS & ctrl_q.trap_en;
  assign flag_exc = trap_flags[fpu_dec_pkg::FLG_INV] ? fpu_dec_pkg::EXC_INVALID
                  : trap_flags[fpu_dec_pkg::FLG_OVF] ? fpu_dec_pkg::EXC_OVERFLOW
                  : trap_flags[fpu_dec_pkg::FLG_UNF] ? fpu_dec_pkg::EXC_UNDERFLOW
                  : trap_flags[fpu_dec_pkg::FLG_INX] ? fpu_dec_pkg::EXC_INEXACT
                  : fpu_dec_pkg::EXC_NONE;
  logic [4:0] add_dest_q;
  state_t state_d;
  always_comb begin
    case (state_q)
      ST_IDLE: state_d = start_add ? ST_ADD : ST_IDLE;
      ST_ADD: state_d = ARITH_DONE ? ST_IDLE : ST_ADD;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      ISSUE_READY <= 1'b1;
      ADD_REQ <= 1'b0;
    end else begin
      state_q <= state_d;
      ISSUE_READY <= state_d == ST_IDLE;
      ADD_REQ <= start_add;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ADD_DOUBLE <= 1'b0;
      ROUND_MODE <= 2'h0;
      ADD_A <= 64'h0;
      ADD_B <= 64'h0;
      add_dest_q <= 5'h00;
    end else if (start_add) begin
      ADD_DOUBLE <= is_dbl;
      ROUND_MODE <= ctrl_q.round_mode;
      ADD_A <= SRC_A;
      ADD_B <= SRC_B;
      add_dest_q <= af.fd;
    end
  end

  // ----------------------------------------------------------------
  // completion
  // ----------------------------------------------------------------
  wire logic fin = (issue_fire & ~start_add) | add_back;
  fpu_dec_pkg::exc_t fin_exc;
  assign fin_exc = add_back ? flag_exc : exc_d;
  wire logic trap = fin & (fin_exc != fpu_dec_pkg::EXC_NONE);
  // a trapping instruction never writes its destination
  wire logic fin_we = add_back ? ~trap : (issue_fire & is_abs & ok);

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DONE <= 1'b0;
      EXC_VALID <= 1'b0;
      EXC_CAUSE <= fpu_dec_pkg::EXC_NONE;
      DEST_WE <= 1'b0;
      DEST_REG <= 5'h00;
      DEST_DATA <= 64'h0;
    end else begin
      DONE <= fin;
      EXC_VALID <= trap;
      EXC_CAUSE <= fin ? fin_exc : fpu_dec_pkg::EXC_NONE;
      DEST_WE <= fin_we;
      DEST_REG <= add_back ? add_dest_q : af.fd;
      DEST_DATA <= add_back ? ARITH_RESULT : abs_val;
    end
  end

  // the slot itself is the host's next issue; only the redirect is ours
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      BR_VALID <= 1'b0;
      BR_TAKEN <= 1'b0;
      BR_TARGET <= 32'h0;
      NULLIFY_SLOT <= 1'b0;
    end else begin
      BR_VALID <= br_ok;
      BR_TAKEN <= br_ok & taken;
      BR_TARGET <= target;
      NULLIFY_SLOT <= br_ok & ~taken & bf.nd;
    end
  end

  // ----------------------------------------------------------------
  // condition bits
  // ----------------------------------------------------------------
  logic have_aw_q;
  logic have_w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire logic wr_go = have_aw_q & have_w_q & ~BVALID;
  wire logic [31:0] lane_m = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
                              {8{wstrb_q[0]}}};
  wire logic [31:0] ctrl_word = 32'(ctrl_q);
  wire logic [31:0] cond_word = 32'(fcc_q);
  wire logic [31:0] ctrl_mrg = (ctrl_word & ~lane_m) | (wdata_q & lane_m);
  wire logic [31:0] cond_mrg = (cond_word & ~lane_m) | (wdata_q & lane_m);
  wire logic wr_ctrl = wr_go & (awaddr_q == fpu_dec_pkg::REG_CTRL);
  wire logic wr_cond = wr_go & (awaddr_q == fpu_dec_pkg::REG_COND);
  wire logic [2:0] cmp_idx = lvl4 ? CMP_SEL : fpu_dec_pkg::SEL_ZERO;
  logic [fpu_dec_pkg::COND_W-1:0] fcc_d;
  always_comb begin
    fcc_d = wr_cond ? cond_mrg[fpu_dec_pkg::COND_W-1:0] : fcc_q;
    // a compare landing with a software write wins its bit
    if (CMP_VALID) begin
      fcc_d[cmp_idx] = CMP_RESULT;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fcc_q <= fpu_dec_pkg::COND_RST;
      c0_prev_q <= 1'b0;
    end else begin
      fcc_q <= fcc_d;
      if (issue_fire) begin
        c0_prev_q <= fcc_q[0];
      end
    end
  end
  assign COND_SIGNAL = fcc_q[0];

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic [TRAP_CNT_W-1:0] trap_cnt_q;
  fpu_dec_pkg::exc_t last_exc_q;
  wire logic aw_fire = AWVALID & AWREADY;
  wire logic w_fire = WVALID & WREADY;
  wire logic b_fire = BVALID & BREADY;
  wire logic ar_fire = ARVALID & ARREADY;
  wire logic wr_mapped = (awaddr_q == fpu_dec_pkg::REG_CTRL)
                       | (awaddr_q == fpu_dec_pkg::REG_COND)
                       | (awaddr_q == fpu_dec_pkg::REG_STATUS);
  wire logic rd_status = ARADDR == fpu_dec_pkg::REG_STATUS;
  wire logic rd_mapped = (ARADDR == fpu_dec_pkg::REG_CTRL)
                       | (ARADDR == fpu_dec_pkg::REG_COND) | rd_status;
  wire logic [31:0] status_word = 32'({trap_cnt_q, 5'h00, last_exc_q});
  wire logic [31:0] rd_word = (ARADDR == fpu_dec_pkg::REG_CTRL) ? ctrl_word
                            : (ARADDR == fpu_dec_pkg::REG_COND) ? cond_word
                            : rd_status ? status_word : 32'h0;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= fpu_dec_pkg::RESP_OKAY;
    end else begin
      AWREADY <= b_fire | (AWREADY & ~aw_fire);
      WREADY <= b_fire | (WREADY & ~w_fire);
      have_aw_q <= aw_fire | (have_aw_q & ~wr_go);
      have_w_q <= w_fire | (have_w_q & ~wr_go);
      BVALID <= wr_go | (BVALID & ~BREADY);
      if (wr_go) begin
        BRESP <= wr_mapped ? fpu_dec_pkg::RESP_OKAY : fpu_dec_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_fire) begin
        awaddr_q <= AWADDR;
      end
      if (w_fire) begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= fpu_dec_pkg::RESP_OKAY;
    end else begin
      ARREADY <= (RVALID & RREADY) | (ARREADY & ~ar_fire);
      RVALID <= ar_fire | (RVALID & ~RREADY);
      if (ar_fire) begin
        RDATA <= rd_word;
        RRESP <= rd_mapped ? fpu_dec_pkg::RESP_OKAY : fpu_dec_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q <= fpu_dec_pkg::CTRL_RST;
      trap_cnt_q <= '0;
      last_exc_q <= fpu_dec_pkg::EXC_NONE;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= fpu_dec_pkg::ctrl_t'(ctrl_mrg[fpu_dec_pkg::CTRL_W-1:0]);
      end
      if (trap) begin
        trap_cnt_q <= trap_cnt_q + 1'b1;
        last_exc_q <= fin_exc;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_add_issued;
    start_add;
  endsequence
  sequence s_add_handed;
    ADD_REQ && !ISSUE_READY && ROUND_MODE == $past(ctrl_q.round_mode);
  endsequence

  chk_add_handoff: assert property (s_add_issued |=> s_add_handed)
    else $error("add not handed off with current rounding mode");
  chk_add_traps: assert property (add_back && trap_flags != 4'h0
      |=> DONE && EXC_VALID && !DEST_WE)
    else $error("enabled add flag did not trap");
  chk_branch_target: assert property (br_ok
      |=> BR_VALID && BR_TARGET == $past(ISSUE_PC) + 32'h4 + $past(off_ext))
    else $error("branch target not relative to delay slot");
  chk_likely_nullify: assert property (br_ok && bf.nd && !taken
      |=> NULLIFY_SLOT && !BR_TAKEN)
    else $error("likely branch slot not nullified");
  chk_lower_level_cond: assert property (br_ok && !lvl4
      |=> BR_TAKEN == ($past(c0_prev_q) == $past(bf.tf)))
    else $error("lower level branch used wrong condition sample");
  chk_sel_zero: assert property (issue_fire && is_bc && !lvl4 && ctrl_q.usable
      && bf.sel != 3'h0 |=> EXC_CAUSE == fpu_dec_pkg::EXC_RESERVED)
    else $error("nonzero selector accepted below level four");
  chk_fixed_unimpl: assert property (issue_fire && is_op && ctrl_q.usable && known
      && !op_bad && (af.fmt == 5'h14 || af.fmt == 5'h15) && !af.funct[5]
      |=> EXC_CAUSE == fpu_dec_pkg::EXC_UNIMPL && !DEST_WE)
    else $error("fixed point operand not trapped");
  chk_abs_sign: assert property (issue_fire && is_abs && ok
      |=> DEST_WE && ((DEST_DATA & $past(sign_mask)) == 64'h0)
      && ((DEST_DATA | $past(sign_mask)) == ($past(SRC_A) | $past(sign_mask))))
    else $error("magnitude result wrong");
  chk_trap_no_write: assert property (EXC_VALID |-> DONE && !DEST_WE && !BR_VALID)
    else $error("trapping instruction had an effect");
endmodule : fpu_branch_decoder

// ---- bench/add_unit_model.sv ----
// add unit stand-in: answers each add request after lat+1 idle cycles
// assumes operands held stable by the decoder from the request on
module add_unit_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic req,
  input wire logic [63:0] a,
  input wire logic [63:0] b,
  input wire logic [3:0] lat,
  // answer
  output logic done,
  output logic [63:0] res,
  output logic [3:0] flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_q;
  logic [3:0] cnt_q;
  // a set sign bit on the first operand stands for an invalid-operation flag
  assign flags = {a[63], 3'h0};
  // integer sum stands in for the datapath; result toggles when not valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      done <= 1'b0;
      res <= 64'h0;
    end else begin
      done <= 1'b0;
      res <= ~res;
      if (req) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
        busy_q <= cnt_q != 4'h0;
        done <= cnt_q == 4'h0;
        if (cnt_q == 4'h0) res <= a + b;
      end
    end
  end
endmodule : add_unit_model

// ---- bench/testbench.sv ----
// self-checking bench of the fp decoder over issue stream and register bus
// assumes one completion per issue in issue order, and bready and rready held high
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK, RSTN, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
  logic RVALID, RREADY, ISSUE_VALID, ISSUE_READY, CMP_VALID, CMP_RESULT, ADD_REQ, ADD_DOUBLE;
  logic ARITH_DONE, DONE, EXC_VALID, DEST_WE, BR_VALID, BR_TAKEN, NULLIFY_SLOT, COND_SIGNAL;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, ISSUE_INSTR, ISSUE_PC, BR_TARGET, pc;
  logic [63:0] SRC_A, SRC_B, ADD_A, ADD_B, ARITH_RESULT, DEST_DATA, sa;
  logic [3:0] WSTRB, ARITH_FLAGS, lat;
  logic [2:0] CMP_SEL, EXC_CAUSE;
  logic [1:0] BRESP, RRESP, ROUND_MODE;
  logic [4:0] DEST_REG;
  logic [15:0] of;
  logic [7:0] cv;
  logic tk;
  logic [101:0] dq[$];
  logic [33:0] rq[$];
  logic [5:0] fn[22] = '{6'h01, 6'h03, 6'h04, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B,
    6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h12, 6'h13, 6'h15, 6'h16, 6'h20, 6'h21, 6'h24, 6'h25, 6'h30};
  logic [4:0] fm[5] = '{5'h10, 5'h11, 5'h14, 5'h15, 5'h12};
  int num_errors = 0;
  int check_count = 0;
  fpu_branch_decoder i_fpu_branch_decoder (.*);
  add_unit_model i_add_unit_model (.clk(SYS_CLK), .rst_n(RSTN), .req(ADD_REQ), .a(ADD_A),
    .b(ADD_B), .lat(lat), .done(ARITH_DONE), .res(ARITH_RESULT), .flags(ARITH_FLAGS));
  task automatic compare(input string nm, input logic [101:0] e, input logic [101:0] s);
    check_count++;
    if (e !== s) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : compare
  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  task automatic tmo(input int n);
    if (n >= 40) begin
      num_errors++;
      results();
    end
  endtask : tmo
  // leaves the request up so that issues can run back to back
  task automatic iss(input logic [31:0] ins, input logic [101:0] e);
    int n;
    n = 0;
    dq.push_back(e);
    {ISSUE_VALID, ISSUE_INSTR, ISSUE_PC, SRC_A, SRC_B} <= {1'b1, ins, pc, sa, sa};
    lat <= 4'($urandom_range(5, 0));
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (ISSUE_READY !== 1'b1 && n < 40);
    tmo(n);
  endtask : iss
  task automatic axw(input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    {AWADDR, WDATA, AWVALID, WVALID} <= {ad, d, 2'b11};
    do begin
      @(posedge SYS_CLK);
      n++;
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && n < 40);
    tmo(n);
  endtask : axw
  task automatic axr(input logic [11:0] ad, input logic [33:0] e);
    int n;
    n = 0;
    rq.push_back(e);
    {ARADDR, ARVALID} <= {ad, 1'b1};
    do begin
      @(posedge SYS_CLK);
      n++;
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && n < 40);
    tmo(n);
  endtask : axr
  always @(posedge SYS_CLK) begin
    if (DONE === 1'b1) compare("done", dq.pop_front(), {EXC_CAUSE, DEST_WE,
      DEST_WE ? DEST_DATA : 64'h0, BR_TAKEN, BR_VALID ? BR_TARGET : 32'h0, NULLIFY_SLOT});
    if (ADD_REQ === 1'b1) compare("round", 102'h6, 102'({ADD_DOUBLE, ROUND_MODE}));
    if (BVALID === 1'b1) compare("bresp", 102'h0, 102'(BRESP));
    if (DONE === 1'b1) compare("exc", 102'(EXC_CAUSE != 3'h0), 102'(EXC_VALID));
    if (RVALID === 1'b1) compare("read", 102'(rq.pop_front()), 102'({RRESP, RDATA}));
  end
  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    {RSTN, AWVALID, WVALID, ARVALID, ISSUE_VALID, CMP_VALID, CMP_RESULT, CMP_SEL} = '0;
    {AWADDR, ARADDR, WDATA, ISSUE_INSTR, ISSUE_PC, SRC_A, SRC_B, lat, pc} = '0;
    {WSTRB, BREADY, RREADY} = '1;
    sa = {$urandom(15), 32'h0};
    repeat (5) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    @(posedge SYS_CLK);
    axr(12'h000, 34'h7);
    axr(12'h00C, {2'h2, 32'h0});
    foreach (fn[i]) foreach (fm[j]) iss({6'h11, fm[j], 15'h0, fn[i]}, {(fm[j] == 5'h12 ||
      (fn[i] == 6'h21 ? fm[j] == 5'h11 : fn[i] == 6'h20 ? fm[j] == 5'h10 : fm[j] > 5'h11))
      ? 3'h3 : 3'h0, 99'h0});
    sa = {$urandom, 1'b1, 31'($urandom)};
    iss({6'h11, 5'h10, 10'h2, 5'h3, 6'h05}, {4'h1, sa & ~64'h8000_0000, 34'h0});
    iss({6'h11, 5'h11, 10'h2, 5'h3, 6'h05}, {4'h1, 1'b0, sa[62:0], 34'h0});
    iss({6'h11, 5'h11, 5'h1, 10'h0, 6'h05}, {3'h2, 99'h0});
    ISSUE_VALID <= 1'b0;
    axw(12'h000, 32'h117);
    sa = 64'hFFF8_0000_0000_0001;
    iss({6'h11, 5'h11, 15'h0, 6'h05}, {3'h4, 99'h0});
    sa = {1'b0, 31'($urandom), $urandom};
    iss({6'h11, 5'h11, 5'h2, 5'h1, 5'h4, 6'h00}, {4'h1, sa + sa, 34'h0});
    sa = {1'b1, 63'($urandom)};
    iss({6'h11, 5'h11, 5'h2, 5'h1, 5'h4, 6'h00}, {3'h4, 99'h0});
    iss({6'h11, 5'h14, 15'h0, 6'h00}, {3'h3, 99'h0});
    ISSUE_VALID <= 1'b0;
    cv = 8'($urandom);
    axw(12'h004, {24'h0, cv});
    for (int k = 0; k < 32; k++) begin
      pc = 32'($urandom) & 32'hFFFF_FFFC;
      of = 16'($urandom);
      tk = cv[k[2:0]] == k[3];
      iss({6'h11, 5'h08, k[2:0], k[4], k[3], of}, {68'h0, tk, pc + 32'h4 + {{14{of[15]}},
        of, 2'b00}, k[4] & !tk});
    end
    ISSUE_VALID <= 1'b0;
    axw(12'h000, 32'h5);
    axw(12'h004, 32'h0);
    pc = 32'h100;
    {CMP_VALID, CMP_RESULT} <= 2'b11;
    iss({6'h11, 5'h10, 15'h0, 6'h06}, 102'h0);
    CMP_VALID <= 1'b0;
    iss({6'h11, 5'h08, 5'h0, 16'h0}, {68'h0, 1'b1, 32'h104, 1'b0});
    iss({6'h11, 5'h10, 15'h0, 6'h06}, 102'h0);
    iss({6'h11, 5'h08, 5'h0, 16'h0}, {68'h0, 1'b0, 32'h104, 1'b0});
    iss({6'h11, 5'h08, 5'h4, 16'h0}, {3'h2, 99'h0});
    ISSUE_VALID <= 1'b0;
    compare("cond", 102'h1, 102'(COND_SIGNAL));
    axw(12'h000, 32'h3);
    iss({6'h11, 5'h08, 5'h0, 16'h0}, {3'h1, 99'h0});
    ISSUE_VALID <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    compare("left", 102'h0, 102'(dq.size() + rq.size()));
    results();
  end
endmodule : testbench
